// >>> rtl/sfi_regs.svh
// constants of the spi transfer and interrupt block
`ifndef SFI_REGS_SVH
`define SFI_REGS_SVH
// ==========================================
// status word field positions
`define SFI_STA_IRQ 0
`define SFI_STA_UNDERRUN 4
`define SFI_STA_TX_IRQ 5
`define SFI_STA_RX_IRQ 6
`define SFI_STA_OVERFLOW 7
`define SFI_STA_RX_LVL_LO 8
`define SFI_STA_RX_LVL_HI 10
`define SFI_STA_RESET 16'h0000
// ==========================================
// timing counts, in serial clock periods and bits
`define SFI_FIRST_RX_PERIODS 12
`define SFI_FIRST_RX_HALVES (2 * `SFI_FIRST_RX_PERIODS)
`define SFI_IRQ_COMMIT_BIT 3
`define SFI_STALL_HALVES 2
`define SFI_LAST_EDGE 15
`define SFI_FIFO_DEPTH 4
`define SFI_BYTE_BITS 8
`endif

// >>> rtl/sfi_pkg.sv
// types of the spi transfer and interrupt block
package sfi_pkg;
	// ==========================================
	// master sequencer states
	typedef enum logic [1:0] {
		SFI_IDLE,
		SFI_SETUP,
		SFI_SHIFT,
		SFI_STALL
	} sfi_mstate_t;
endpackage : sfi_pkg

// >>> rtl/sfi_fifo.sv
// byte fifo with overwrite-oldest support, used for transmit and receive
`timescale 1ns/10ps
module sfi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic flush,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	input wire logic pop,
	output logic [WIDTH-1:0] head,
	output logic [$clog2(DEPTH+1)-1:0] count,
	output logic full,
	output logic empty
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	// ==========================================
	// storage and pointers
	logic [WIDTH-1:0] mem [DEPTH]; // entries
	logic [AW-1:0] wr_ptr; // next free slot
	logic [AW-1:0] rd_ptr; // oldest entry
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [CW-1:0] next_count;
	logic do_push; // accepted write
	logic do_pop; // accepted read

	assign full = (count == CW'(DEPTH));
	assign empty = (count == '0);
	assign head = mem[rd_ptr];
	// a pop when full makes room, so push with pop on a full fifo overwrites the oldest
	assign do_pop = pop && !empty;
	assign do_push = push && (!full || do_pop);

	// ==========================================
	// pointer and level update
	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (flush) begin
			// flush empties at once, any request is dropped
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_count = '0;
		end else begin
			if (do_push) begin
				next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (do_pop) begin
				next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (do_push && !do_pop) begin
				next_count = count + 1'b1;
			end else if (do_pop && !do_push) begin
				next_count = count - 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// data words carry no reset, only the pointers matter
	always_ff @(posedge clk) begin
		if (do_push && !flush) begin
			mem[wr_ptr] <= push_data;
		end
	end
endmodule : sfi_fifo

// >>> rtl/sfi_spi_port.sv
// spi port transfer control, fifos and interrupt sources, master or slave
`timescale 1ns/10ps
`include "sfi_regs.svh"

// Notes on behaviour
// - master, tx irq mode: fifo write starts transfer
// - master, rx mode: idle rx read starts transfer
// - always receives; rx flush drops bytes, irqs
// - tx flush suppresses underrun interrupts
// - first written byte loads shifter at once
// - continuous: chip select held while data queued
// - non-continuous: one byte, stall between bytes
// - read start moves threshold-plus-one bytes, four max
// - slave: chip select frames byte exchanges
// - empty fifo sends last byte or zeros
// - full rx: overwrite oldest or drop new
// - tx/underrun flag three bits into byte
// - master: rx level hides first byte twelve periods
// - one line, status bit 0, sources 7:4
// - tx irq mode picks tx or rx interrupt
// - tx interrupt every first..fourth popped byte
// - tx flag at bit 5, read clears
// - control write zeroes sent-byte counter
// - rx flag on push when level exceeds threshold
// - empty start sets underrun bit 4
// - push into full sets overflow bit 7
// - flags clear on read, disable, flush
// - master drives chip select per transfer
// - half serial period is divider plus one
module sfi_spi_port
	import sfi_pkg::*;
#(
	parameter int DIVW = 8,
	parameter int DEPTH = `SFI_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic port_enable,
	input wire logic master_mode,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic transfer_irq_mode,
	input wire logic underrun_zero_fill,
	input wire logic overflow_overwrite_or_flag,
	input wire logic cont_mode,
	input wire logic tx_flush,
	input wire logic rx_flush,
	input wire logic [1:0] irq_mode,
	input wire logic [DIVW-1:0] bit_rate_divider,
	input wire logic ctrl_write,
	input wire logic status_rd,
	input wire logic tx_wr_valid,
	input wire logic [7:0] tx_wr_data,
	output logic tx_wr_ready,
	input wire logic rx_rd,
	output logic [7:0] rx_rd_data,
	output logic [15:0] port_status_reg,
	output logic irq,
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe_n,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe_n,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe_n,
	input wire logic cs_n_in,
	output logic chip_select_n,
	output logic cs_oe_n
);
	localparam int CW = $clog2(DEPTH+1);
	// ==========================================
	// pin input synchronisers
	logic [3:0] pin_raw; // sclk, mosi, miso, cs
	logic [3:0] pin_s1; // first stage, read only by the second
	logic [3:0] pin_s2; // safe copies
	logic sclk_prev; // last safe sclk for edge finding
	logic cs_prev; // last safe chip select
	assign pin_raw = {sclk_in, mosi_in, miso_in, cs_n_in};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (!rstn) begin
					pin_s1[gi] <= 1'b1;
					pin_s2[gi] <= 1'b1;
				end else begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s1[gi];
				end
			end
		end
	endgenerate
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sclk_prev <= 1'b0;
			cs_prev <= 1'b1;
		end else begin
			sclk_prev <= pin_s2[3];
			cs_prev <= pin_s2[0];
		end
	end

	// ==========================================
	// fifos
	logic tx_push, tx_pop, tx_full, tx_empty;
	logic [7:0] tx_head;
	logic [CW-1:0] tx_count;
	logic rx_push, rx_pop, rx_full, rx_empty;
	logic [7:0] rx_push_data;
	logic [CW-1:0] rx_count;
	assign tx_wr_ready = !tx_full && !tx_flush;
	assign tx_push = tx_wr_valid && tx_wr_ready;
	assign rx_pop = rx_rd || (rx_push && rx_full && overflow_overwrite_or_flag);
	sfi_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
		.clk(clk), .rstn(rstn), .flush(tx_flush), .push(tx_push), .push_data(tx_wr_data),
		.pop(tx_pop), .head(tx_head), .count(tx_count), .full(tx_full), .empty(tx_empty)
	);
	sfi_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
		.clk(clk), .rstn(rstn), .flush(rx_flush), .push(rx_push && !rx_flush),
		.pop(rx_pop), .push_data(rx_push_data), .head(rx_rd_data), .count(rx_count),
		.full(rx_full), .empty(rx_empty)
	);

	// ==========================================
	// master sequencer
	sfi_mstate_t mstate, next_mstate; // sequencer state
	logic [DIVW-1:0] div_cnt, next_div_cnt; // half period timer
	logic [3:0] edge_cnt, next_edge_cnt; // serial clock edge index
	logic sclk_lvl, next_sclk_lvl; // driven clock level
	logic cs_n, next_cs_n; // driven chip select
	logic read_init, next_read_init; // transfer started by a read
	logic [2:0] bytes_left, next_bytes_left; // bytes still owed to a read start
	logic tick; // one half serial period elapsed
	logic m_run; // master logic active
	logic more; // another byte follows
	logic m_load; // master loads the shifter
	assign m_run = port_enable && master_mode;
	// the timer keeps running while idle, so a held receive byte still ages
	assign tick = (div_cnt == bit_rate_divider);
	assign more = read_init ? (bytes_left != 3'd1) : !tx_empty;
	assign m_load = (next_mstate == SFI_SETUP) && (mstate != SFI_SETUP);

	// next state of the master sequencer
	always_comb begin
		next_mstate = mstate;
		next_div_cnt = tick ? '0 : div_cnt + 1'b1;
		next_edge_cnt = edge_cnt;
		next_sclk_lvl = sclk_lvl;
		next_cs_n = cs_n;
		next_read_init = read_init;
		next_bytes_left = bytes_left;
		unique case (mstate)
			SFI_IDLE: begin
				next_sclk_lvl = cpol; // idle level follows polarity
				if (m_run && transfer_irq_mode && !tx_empty) begin
					next_mstate = SFI_SETUP;
					next_read_init = 1'b0;
				end else if (m_run && !transfer_irq_mode && rx_rd) begin
					next_mstate = SFI_SETUP;
					next_read_init = 1'b1;
					next_bytes_left = {1'b0, irq_mode} + 3'd1;
				end
				if (next_mstate == SFI_SETUP) begin
					next_cs_n = 1'b0;
					next_div_cnt = '0; // setup starts on a fresh half period
				end
			end
			SFI_SETUP: begin
				// half period of data setup before the first edge
				if (tick) begin
					next_mstate = SFI_SHIFT;
					next_edge_cnt = '0;
				end
			end
			SFI_SHIFT: begin
				if (tick) begin
					next_sclk_lvl = !sclk_lvl;
					next_edge_cnt = edge_cnt + 1'b1;
					if (edge_cnt == 4'(`SFI_LAST_EDGE)) begin
						if (more) begin
							next_bytes_left = bytes_left - 3'd1;
							if (cont_mode) begin
								next_mstate = SFI_SETUP;
							end else begin
								next_mstate = SFI_STALL;
								next_cs_n = 1'b1;
								next_edge_cnt = '0;
							end
						end else begin
							next_mstate = SFI_IDLE;
							next_cs_n = 1'b1;
						end
					end
				end
			end
			SFI_STALL: begin
				// chip select high for one whole serial period
				if (tick) begin
					next_edge_cnt = edge_cnt + 1'b1;
					if (edge_cnt == 4'(`SFI_STALL_HALVES - 1)) begin
						next_mstate = SFI_SETUP;
						next_cs_n = 1'b0;
					end
				end
			end
		endcase
		if (!m_run) begin
			// disabling or leaving master mode aborts at once
			next_mstate = SFI_IDLE;
			next_cs_n = 1'b1;
			next_sclk_lvl = cpol;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			mstate <= SFI_IDLE;
			div_cnt <= '0;
			edge_cnt <= '0;
			sclk_lvl <= 1'b0;
			cs_n <= 1'b1;
			read_init <= 1'b0;
			bytes_left <= '0;
		end else begin
			mstate <= next_mstate;
			div_cnt <= next_div_cnt;
			edge_cnt <= next_edge_cnt;
			sclk_lvl <= next_sclk_lvl;
			cs_n <= next_cs_n;
			read_init <= next_read_init;
			bytes_left <= next_bytes_left;
		end
	end

	// ==========================================
	// shared shift engine, fed by master timing or slave edges
	logic s_act; // slave framed by the far master
	logic s_cs_fall; // slave frame start
	logic lead, trail, sample, launch; // edge strobes
	logic din; // serial input of the active role
	logic byte_done; // eighth bit sampled
	logic load; // shifter takes a new byte
	logic [7:0] tx_shift, next_tx_shift; // outgoing byte
	logic [7:0] rx_shift, next_rx_shift; // incoming byte
	logic [7:0] last_tx, next_last_tx; // byte resent on underrun
	logic [2:0] bit_cnt, next_bit_cnt; // bits sampled in this byte
	assign s_act = port_enable && !master_mode && !pin_s2[0];
	assign s_cs_fall = s_act && cs_prev;
	// leading edge leaves the idle level, trailing edge returns to it
	assign lead = m_run ? (tick && mstate == SFI_SHIFT && !edge_cnt[0])
		: (s_act && sclk_prev == cpol && pin_s2[3] != cpol);
	assign trail = m_run ? (tick && mstate == SFI_SHIFT && edge_cnt[0])
		: (s_act && sclk_prev != cpol && pin_s2[3] == cpol);
	assign sample = cpha ? trail : lead;
	assign launch = cpha ? lead : trail;
	assign din = m_run ? pin_s2[1] : pin_s2[2];
	assign byte_done = sample && (bit_cnt == 3'd7);
	assign load = m_run ? m_load : (s_cs_fall || (s_act && byte_done));
	assign tx_pop = load && !tx_empty;

	// next shifter contents
	always_comb begin
		next_tx_shift = tx_shift;
		next_rx_shift = rx_shift;
		next_last_tx = last_tx;
		next_bit_cnt = bit_cnt;
		if (sample) begin
			next_rx_shift = {rx_shift[6:0], din};
			next_bit_cnt = bit_cnt + 1'b1;
		end
		if (launch && bit_cnt != 3'd0) begin
			next_tx_shift = {tx_shift[6:0], 1'b0};
		end
		if (load) begin
			if (!tx_empty) begin
				next_tx_shift = tx_head;
				next_last_tx = tx_head;
			end else begin
				next_tx_shift = underrun_zero_fill ? 8'h00 : last_tx;
			end
		end
		if ((m_run && m_load) || s_cs_fall || !(m_run || s_act)) begin
			next_bit_cnt = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			tx_shift <= 8'h00;
			rx_shift <= 8'h00;
			last_tx <= 8'h00;
			bit_cnt <= 3'h0;
		end else begin
			tx_shift <= next_tx_shift;
			rx_shift <= next_rx_shift;
			last_tx <= next_last_tx;
			bit_cnt <= next_bit_cnt;
		end
	end

	// ==========================================
	// receive hold: the first byte of a master frame waits twelve periods
	logic [4:0] halves, next_halves; // half periods since chip select fell
	logic hold_v, next_hold_v; // byte held back
	logic [7:0] hold_d, next_hold_d; // held byte
	logic frame_fall; // master chip select falls
	logic first_byte, next_first_byte; // next byte is the first of its frame
	logic hold_open; // hold time elapsed
	assign frame_fall = m_run && cs_n && !next_cs_n;
	assign hold_open = (halves >= 5'(`SFI_FIRST_RX_HALVES)) || frame_fall || !m_run;

	always_comb begin
		next_halves = halves;
		next_hold_v = hold_v;
		next_hold_d = hold_d;
		next_first_byte = first_byte;
		rx_push = 1'b0;
		rx_push_data = rx_shift;
		if (frame_fall) begin
			next_halves = '0;
			next_first_byte = 1'b1;
		end else if (tick && halves < 5'(`SFI_FIRST_RX_HALVES)) begin
			next_halves = halves + 1'b1;
		end
		if (hold_v && hold_open) begin
			rx_push = 1'b1;
			rx_push_data = hold_d;
			next_hold_v = 1'b0;
		end else if (byte_done) begin
			if (m_run && first_byte && !hold_open) begin
				next_hold_v = 1'b1;
				next_hold_d = next_rx_shift;
			end else begin
				rx_push = 1'b1;
				rx_push_data = next_rx_shift;
			end
			next_first_byte = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			halves <= '0;
			hold_v <= 1'b0;
			hold_d <= 8'h00;
			first_byte <= 1'b0;
		end else begin
			halves <= next_halves;
			hold_v <= next_hold_v;
			hold_d <= next_hold_d;
			first_byte <= next_first_byte;
		end
	end

	// ==========================================
	// interrupt sources
	logic [1:0] sent_cnt, next_sent_cnt; // popped bytes since last tx event
	logic tx_pend, next_tx_pend; // tx event awaiting its bit position
	logic ur_pend, next_ur_pend; // underrun awaiting its bit position
	logic f_ur, f_tx, f_rx, f_ov; // sticky flags
	logic next_f_ur, next_f_tx, next_f_rx, next_f_ov;
	logic commit; // third bit of the byte sampled
	logic clr_all; // read or disable
	assign commit = sample && (bit_cnt == 3'(`SFI_IRQ_COMMIT_BIT - 1));
	assign clr_all = status_rd || !port_enable;

	always_comb begin
		next_sent_cnt = sent_cnt;
		next_tx_pend = tx_pend;
		next_ur_pend = ur_pend;
		next_f_ur = f_ur;
		next_f_tx = f_tx;
		next_f_rx = f_rx;
		next_f_ov = f_ov;
		if (tx_pop) begin
			if (sent_cnt == irq_mode) begin
				next_sent_cnt = '0;
				next_tx_pend = 1'b1;
			end else begin
				next_sent_cnt = sent_cnt + 1'b1;
			end
		end
		if (ctrl_write) begin
			next_sent_cnt = '0;
		end
		if (load && tx_empty) begin
			next_ur_pend = 1'b1;
		end
		// a read clears first, so an event in the same cycle wins; disable clears again last, so it wins
		if (clr_all) begin
			next_f_ur = 1'b0;
			next_f_tx = 1'b0;
			next_f_rx = 1'b0;
			next_f_ov = 1'b0;
		end
		if (commit) begin
			next_tx_pend = 1'b0;
			next_ur_pend = 1'b0;
			if (tx_pend && transfer_irq_mode) begin
				next_f_tx = 1'b1;
			end
			if (ur_pend) begin
				next_f_ur = 1'b1;
			end
		end
		if (rx_push && !transfer_irq_mode) begin
			// level after this push, overwrite keeps it full
			if ((rx_full ? CW'(DEPTH) : rx_count + 1'b1) > CW'(irq_mode)) begin
				next_f_rx = 1'b1;
			end
		end
		if (rx_push && rx_full) begin
			next_f_ov = 1'b1;
		end
		if (tx_flush) begin
			next_f_ur = 1'b0;
			next_f_tx = 1'b0;
			next_tx_pend = 1'b0;
			next_ur_pend = 1'b0;
		end
		if (rx_flush) begin
			next_f_rx = 1'b0;
			next_f_ov = 1'b0;
		end
		if (!port_enable) begin
			next_f_ur = 1'b0;
			next_f_tx = 1'b0;
			next_f_rx = 1'b0;
			next_f_ov = 1'b0;
			next_tx_pend = 1'b0;
			next_ur_pend = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sent_cnt <= '0;
			tx_pend <= 1'b0;
			ur_pend <= 1'b0;
			f_ur <= 1'b0;
			f_tx <= 1'b0;
			f_rx <= 1'b0;
			f_ov <= 1'b0;
		end else begin
			sent_cnt <= next_sent_cnt;
			tx_pend <= next_tx_pend;
			ur_pend <= next_ur_pend;
			f_ur <= next_f_ur;
			f_tx <= next_f_tx;
			f_rx <= next_f_rx;
			f_ov <= next_f_ov;
		end
	end

	// ==========================================
	// status word, interrupt line and pins
	always_comb begin
		port_status_reg = `SFI_STA_RESET;
		port_status_reg[`SFI_STA_UNDERRUN] = f_ur;
		port_status_reg[`SFI_STA_TX_IRQ] = f_tx;
		port_status_reg[`SFI_STA_RX_IRQ] = f_rx;
		port_status_reg[`SFI_STA_OVERFLOW] = f_ov;
		port_status_reg[`SFI_STA_RX_LVL_HI:`SFI_STA_RX_LVL_LO] = 3'(rx_count);
		port_status_reg[`SFI_STA_IRQ] = irq;
	end
	assign irq = f_ur || f_tx || f_rx || f_ov;
	assign sclk_out = sclk_lvl;
	assign chip_select_n = cs_n;
	assign mosi_out = tx_shift[7];
	assign miso_out = tx_shift[7];
	assign sclk_oe_n = !m_run;
	assign cs_oe_n = !m_run;
	assign mosi_oe_n = !m_run;
	assign miso_oe_n = !s_act; // slave drives only while selected
endmodule : sfi_spi_port

// >>> tb/sfi_spi_port_props.sv
// assertion checker of the spi transfer and interrupt port
`timescale 1ns/10ps
module sfi_spi_port_props
	import sfi_pkg::*;
#(
	parameter int DIVW = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic port_enable,
	input wire logic master_mode,
	input wire logic cpol,
	input wire logic transfer_irq_mode,
	input wire logic tx_flush,
	input wire logic rx_flush,
	input wire logic tx_wr_ready,
	input wire logic [15:0] port_status_reg,
	input wire logic irq,
	input wire logic sclk_out,
	input wire logic sclk_oe_n,
	input wire logic mosi_oe_n,
	input wire logic miso_oe_n,
	input wire logic chip_select_n,
	input wire logic cs_oe_n
);
	// ==========================================
	// one clock domain, reset disables all
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// ==========================================
	// interrupt line and flags
	AST_IRQ_LINE: assert property (irq == (|port_status_reg[7:4]))
		else $error("irq is not the or of the four flags");
	AST_STA_MIRROR: assert property (port_status_reg[0] == irq)
		else $error("status bit 0 differs from irq");
	AST_DISABLE_CLEAR: assert property (!port_enable [*2] |-> port_status_reg[7:4] == 4'h0)
		else $error("flags survive port disable");
	AST_TX_FLUSH: assert property (tx_flush [*2] |-> port_status_reg[5:4] == 2'h0)
		else $error("tx side flag while tx flush held");
	AST_RX_FLUSH: assert property (rx_flush [*2] |-> port_status_reg[7:6] == 2'h0)
		else $error("rx side flag while rx flush held");
	AST_FLUSH_READY: assert property (tx_flush |-> !tx_wr_ready)
		else $error("tx write accepted during tx flush");
	AST_TX_SOURCE: assert property ($rose(port_status_reg[5]) |-> $past(transfer_irq_mode))
		else $error("tx flag rose in rx irq mode");
	AST_RX_SOURCE: assert property ($rose(port_status_reg[6]) |-> !$past(transfer_irq_mode))
		else $error("rx flag rose in tx irq mode");
	// ==========================================
	// master pin behaviour
	AST_STALL: assert property ($rose(chip_select_n) && master_mode |-> chip_select_n [*2])
		else $error("chip select stall too short");
	AST_SCLK_IDLE: assert property (master_mode && chip_select_n && $past(chip_select_n, 2)
		&& $stable(cpol) |-> sclk_out == cpol)
		else $error("serial clock not at idle level");
	// a disabled port releases every pin, so only an enabled master is checked
	AST_MASTER_PINS: assert property (master_mode && port_enable && $past(master_mode, 2)
		|-> !sclk_oe_n && !mosi_oe_n && !cs_oe_n && miso_oe_n)
		else $error("master pin enables wrong");
	// ==========================================
	// main scenarios reached
	cover property ($fell(chip_select_n));
	cover property ($rose(port_status_reg[4]));
	cover property ($rose(port_status_reg[7]));
endmodule : sfi_spi_port_props

bind sfi_spi_port sfi_spi_port_props #(.DIVW(DIVW), .DEPTH(DEPTH)) u_props (.clk, .rstn,
	.port_enable, .master_mode, .cpol, .transfer_irq_mode, .tx_flush, .rx_flush,
	.tx_wr_ready, .port_status_reg, .irq, .sclk_out, .sclk_oe_n, .mosi_oe_n, .miso_oe_n,
	.chip_select_n, .cs_oe_n);

// >>> tb/sfi_slave_model.sv
// external spi slave for mode 0, sends its own byte count
`timescale 1ns/10ps
module sfi_slave_model
	import sfi_pkg::*;
(
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic [7:0] got,
	output logic [7:0] n_bytes
);
	// ==========================================
	// shift state
	logic [7:0] sh_out; // byte being sent
	logic [7:0] sh_in; // byte being taken
	logic [2:0] nbit; // samples in this byte
	initial begin
		miso = 1'b1;
		got = 8'h00;
		n_bytes = 8'h00;
		sh_out = 8'h00;
		sh_in = 8'h00;
		nbit = 3'h0;
	end
	// frame start: first bit ready before the first edge
	always @(negedge cs_n) begin
		sh_out = n_bytes;
		nbit = 3'h0;
		miso = sh_out[7];
	end
	// sample on leading edge, msb first
	always @(posedge sclk) begin
		if (!cs_n) begin
			sh_in = {sh_in[6:0], mosi};
			nbit = nbit + 3'h1;
			if (nbit == 3'h0) begin
				got = sh_in;
				n_bytes = n_bytes + 8'h01;
			end
		end
	end
	// launch on trailing edge, next byte after eight samples
	always @(negedge sclk) begin
		if (!cs_n && nbit == 3'h0) begin
			sh_out = n_bytes;
		end else if (!cs_n) begin
			sh_out = sh_out << 1;
		end
		if (!cs_n) begin
			miso = sh_out[7];
		end
	end
	// released line: show the inverse so stale data cannot pass
	always @(posedge cs_n) begin
		miso = ~miso;
	end
endmodule : sfi_slave_model

// >>> tb/sfi_spi_port_bench.sv
// self-checking bench of the spi transfer and interrupt port in master mode
`timescale 1ns/10ps
module sfi_spi_port_bench
	import sfi_pkg::*;
;
	// ==========================================
	// stimulus, pins and counters
	logic clk, rstn, port_enable, master_mode, cpol, cpha, tmode, zfill, ovw, cont;
	logic tx_flush, rx_flush, ctrl_write, status_rd, tx_wr_valid, tx_wr_ready, rx_rd, irq;
	logic [1:0] irq_mode;
	logic [7:0] div, tx_wr_data, rx_rd_data, got, n_bytes;
	logic [15:0] sta;
	logic sclk_out, sclk_oe_n, mosi_out, mosi_oe_n, miso_m, miso_out, miso_oe_n, cs_n, cs_oe_n;
	logic sclk_w, mosi_w, miso_w, cs_w;
	int err_count, n_checks, cycles, n_fall;
	// wire levels from every enable; chip select pulled up
	assign sclk_w = sclk_oe_n ? 1'b0 : sclk_out;
	assign mosi_w = mosi_oe_n ? 1'b0 : mosi_out;
	assign miso_w = miso_oe_n ? miso_m : miso_out;
	assign cs_w = cs_oe_n ? 1'b1 : cs_n;
	// ==========================================
	// design and far side
	sfi_spi_port dut (.clk(clk), .rstn(rstn), .port_enable(port_enable),
		.master_mode(master_mode), .cpol(cpol), .cpha(cpha), .transfer_irq_mode(tmode),
		.underrun_zero_fill(zfill), .overflow_overwrite_or_flag(ovw), .cont_mode(cont),
		.tx_flush(tx_flush), .rx_flush(rx_flush), .irq_mode(irq_mode),
		.bit_rate_divider(div), .ctrl_write(ctrl_write), .status_rd(status_rd),
		.tx_wr_valid(tx_wr_valid), .tx_wr_data(tx_wr_data), .tx_wr_ready(tx_wr_ready),
		.rx_rd(rx_rd), .rx_rd_data(rx_rd_data), .port_status_reg(sta), .irq(irq),
		.sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .mosi_in(mosi_w),
		.mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_w), .miso_out(miso_out),
		.miso_oe_n(miso_oe_n), .cs_n_in(cs_w), .chip_select_n(cs_n), .cs_oe_n(cs_oe_n));
	sfi_slave_model far (.sclk(sclk_w), .cs_n(cs_w), .mosi(mosi_w), .miso(miso_m),
		.got(got), .n_bytes(n_bytes));
	// ==========================================
	// clock, frame counter, hang guard
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(negedge cs_w) n_fall++;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			summarize();
		end
	end
	// ==========================================
	// access tasks
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse
	// fifo is empty at every call, so ready is high at the take
	task wr_byte(input logic [7:0] d);
		tx_wr_data = d;
		tx_wr_valid = 1'b1;
		tick(1);
		tx_wr_valid = 1'b0;
	endtask : wr_byte
	task rd_status();
		pulse(status_rd);
		tick(1);
	endtask : rd_status
	// wait out n chip select frames, then let the late rx push land
	task frames(input int n);
		int k;
		for (int i = 0; i < n; i++) begin
			k = 0;
			while (cs_w !== 1'b0 && k < 400) begin
				tick(1);
				k++;
			end
			k = 0;
			while (cs_w !== 1'b1 && k < 2000) begin
				tick(1);
				k++;
			end
		end
		tick(90);
	endtask : frames
	task chk8(input string name, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask : chk8
	task summarize();
		if (err_count == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : summarize
	// ==========================================
	// main sequence; divider 2 gives 3 clk half periods
	initial begin
		{rstn, port_enable, cpol, cpha, tmode, zfill, ovw, cont} = 8'h00;
		{tx_flush, rx_flush, ctrl_write, status_rd, tx_wr_valid, rx_rd} = 6'h00;
		master_mode = 1'b1;
		irq_mode = 2'h0;
		div = 8'h02;
		tx_wr_data = 8'h00;
		tick(5);
		rstn = 1'b1;
		tick(2);
		port_enable = 1'b1;
		tick(3);
		// write-started byte with tx irq each byte
		tmode = 1'b1;
		wr_byte(8'ha5);
		frames(1);
		chk8("mosi byte", 8'ha5, got);
		chk8("tx flag", 8'h01, {7'h0, sta[5]});
		chk8("irq bit", 8'h01, {7'h0, sta[0]});
		chk8("rx level", 8'h01, {5'h0, sta[10:8]});
		chk8("rx data", 8'h00, rx_rd_data);
		rd_status();
		chk8("read clear", 8'h00, {4'h0, sta[7:4]});
		pulse(rx_rd);
		// read-started bytes from an empty tx fifo, both fill policies
		tmode = 1'b0;
		pulse(ctrl_write);
		for (int i = 0; i < 2; i++) begin
			zfill = (i == 1);
			pulse(rx_rd);
			frames(1);
			chk8("fill byte", (i == 1) ? 8'h00 : 8'ha5, got);
			chk8("underrun", 8'h01, {7'h0, sta[4]});
			chk8("rx flag", 8'h01, {7'h0, sta[6]});
			chk8("rx head", 8'(i + 1), rx_rd_data);
			rd_status();
		end
		// tx flush hides underrun; rx flush empties and clears
		tx_flush = 1'b1;
		pulse(rx_rd);
		frames(1);
		chk8("masked underrun", 8'h00, {7'h0, sta[4]});
		tx_flush = 1'b0;
		rx_flush = 1'b1;
		tick(2);
		rx_flush = 1'b0;
		chk8("flushed", 8'h00, {5'h0, sta[10:8]});
		chk8("flushed rx flag", 8'h00, {7'h0, sta[6]});
		// control write restarts the every-second-byte count
		tmode = 1'b1;
		irq_mode = 2'h1;
		pulse(ctrl_write);
		wr_byte(8'h11);
		frames(1);
		pulse(ctrl_write);
		wr_byte(8'h22);
		frames(1);
		chk8("tx flag reset", 8'h00, {7'h0, sta[5]});
		wr_byte(8'h33);
		frames(1);
		chk8("tx flag second", 8'h01, {7'h0, sta[5]});
		chk8("rx flag off", 8'h00, {7'h0, sta[6]});
		rx_flush = 1'b1;
		tick(2);
		rx_flush = 1'b0;
		// four-byte read start, stalled then continuous into a full fifo
		tmode = 1'b0;
		irq_mode = 2'h3;
		pulse(ctrl_write);
		rd_status();
		n_fall = 0;
		pulse(rx_rd);
		frames(4);
		chk8("stalled frames", 8'h04, 8'(n_fall));
		chk8("four bytes", 8'h04, {5'h0, sta[10:8]});
		chk8("rx flag full", 8'h01, {7'h0, sta[6]});
		rd_status();
		cont = 1'b1;
		n_fall = 0;
		pulse(rx_rd);
		frames(1);
		chk8("cont frames", 8'h01, 8'(n_fall));
		chk8("sent bytes", 8'h0f, n_bytes);
		chk8("overflow", 8'h01, {7'h0, sta[7]});
		chk8("dropped new", 8'h08, rx_rd_data);
		// overwrite policy: the three oldest give way, newest four stay
		ovw = 1'b1;
		pulse(rx_rd);
		frames(1);
		chk8("overwrite head", 8'h0f, rx_rd_data);
		port_enable = 1'b0;
		tick(2);
		chk8("disable clear", 8'h00, {4'h0, sta[7:4]});
		summarize();
	end
endmodule : sfi_spi_port_bench
